// >>> core/video_scale_convert_capture.v
// Implementation choices: the register addresses and the Avalon-MM slave port.
`include "video_scale_convert_capture_defs.vh"
`default_nettype none

module video_scale_convert_capture #(
   parameter DIM_W = 12
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Avalon-MM register slave (byte address)
   input  wire [4:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   output reg  [31:0] avsReadData,
   output wire        avsWaitRequest,
   // PCI configuration bus-master enable
   input  wire        busMasterEnable,
   // Video input, one pixel per beat, chroma alternates U then V
   input  wire        vidValid,
   output wire        vidReady,
   input  wire [7:0]  vidY,
   input  wire [7:0]  vidC,
   input  wire        vidLineStart,
   input  wire        vidVsync,
   input  wire        vidOddField,
   // DMA write words toward PCI
   output reg         dmaValid,
   input  wire        dmaReady,
   output reg  [31:0] dmaAddress,
   output reg  [31:0] dmaData
);

   // ==========================================
   // Helpers
   function dropHit;
      input [5:0] pos;
      input [5:0] cnt;
      reg   [11:0] a;
      reg   [11:0] b;
      begin
         a = {6'h00, pos} * {6'h00, cnt};
         b = a + {6'h00, cnt};
         dropHit = (a[11:6] != b[11:6]);
      end
   endfunction

   function [7:0] filt;
      input [2:0]  sel;
      input        luma;
      input [39:0] h;
      reg   [11:0] s;
      reg   [11:0] h0, h1, h2, h3, h4;
      begin
         h0 = {4'h0, h[7:0]};
         h1 = {4'h0, h[15:8]};
         h2 = {4'h0, h[23:16]};
         h3 = {4'h0, h[31:24]};
         h4 = {4'h0, h[39:32]};
         case (sel)
            3'h1: s = (h0 + (h1 << 1) + h2) >> 2;
            3'h2: s = (h0 + 12'h003 * h1 + 12'h003 * h2 + h3) >> 3;
            3'h3: s = luma ? (h0 + (h1 << 2) + 12'h006 * h2 + (h3 << 2) + h4) >> 4
                           : (h0 + 12'h003 * h1 + 12'h003 * h2 + h3) >> 3;
            3'h4: s = (h0 + h1 + h2 + h3) >> 2;
            // Select 0 passes luma straight through, so it stays aligned to its pixel
            default: s = luma ? h0 : (h0 + (h1 << 1) + h2) >> 2;
         endcase
         filt = s[7:0];
      end
   endfunction

   function [7:0] clamp;
      input signed [17:0] v;
      begin
         if (v < 0)
            clamp = 8'h00;
         else if (v > 18'sd255)
            clamp = 8'hFF;
         else
            clamp = v[7:0];
      end
   endfunction

   // ==========================================
   // Register file
   localparam [2:0] ST_LIVE = 3'h0, ST_FREEZE_WAIT = 3'h1, ST_FROZEN = 3'h2,
                    ST_GRAB_WAIT = 3'h3, ST_GRAB = 3'h4, ST_RESUME_WAIT = 3'h5;

   reg  [31:0] control;
   reg  [31:0] scale;
   reg  [31:0] topBase;
   reg  [31:0] bottomBase;
   reg  [31:0] stride;
   reg  [31:0] window;
   reg         ack;
   reg  [2:0]  state;
   reg  [1:0]  fieldsDone;
   reg         curBottom;
   wire        grabDone;

   wire        video_dma_on         = control[`CTL_DMA_ON];
   wire        field_display_select = control[`CTL_FIELD_DISP];
   wire        capture_mode         = control[`CTL_CAPTURE];
   wire        grab_trigger         = control[`CTL_GRAB];
   wire        field_dup_mode       = control[`CTL_DUP];
   wire        error_diffusion_on   = control[`CTL_ERROR_DIFFUSION_ON];
   wire [1:0]  color_convert_select = control[`CTL_COLOR_HI:`CTL_COLOR_LO];
   wire [2:0]  horiz_filter_select  = control[`CTL_FILTER_HI:`CTL_FILTER_LO];
   wire [5:0]  horiz_drop_count     = scale[5:0];
   wire [5:0]  vert_drop_count      = scale[13:8];
   wire [DIM_W-1:0] window_width    = window[DIM_W-1:0];
   wire [DIM_W-1:0] window_height   = window[16+DIM_W-1:16];

   wire        busReq  = avsRead | avsWrite;
   wire        doWrite = avsWrite & ack;
   wire        paramOpen = ~video_dma_on | (capture_mode & ~grab_trigger);

   // One wait state: request seen, answered on the next edge
   assign avsWaitRequest = busReq & ~ack;

   always @(posedge clk) begin
      if (reset) begin
         ack         <= 1'b0;
         avsReadData <= `RST_WORD;
         control     <= `RST_CONTROL;
         scale       <= `RST_WORD;
         topBase     <= `RST_WORD;
         bottomBase  <= `RST_WORD;
         stride      <= `RST_WORD;
         window      <= `RST_WORD;
      end else begin
         ack <= busReq & ~ack;
         if (avsRead & ~ack) begin
            case (avsAddress)
               `REG_CONTROL:     avsReadData <= control;
               `REG_SCALE:       avsReadData <= scale;
               `REG_TOP_BASE:    avsReadData <= topBase;
               `REG_BOTTOM_BASE: avsReadData <= bottomBase;
               `REG_STRIDE:      avsReadData <= stride;
               `REG_WINDOW:      avsReadData <= window;
               `REG_STATUS:      avsReadData <= {26'h0000000, fieldsDone, curBottom, state};
               default:          avsReadData <= `RST_WORD;
            endcase
         end
         if (doWrite && avsAddress == `REG_CONTROL) begin
            control[10:0] <= avsWriteData[10:0];
            // trigger only armed in capture mode
            control[`CTL_GRAB] <= avsWriteData[`CTL_GRAB] & avsWriteData[`CTL_CAPTURE];
         end else if (grabDone) begin
            control[`CTL_GRAB] <= 1'b0;
         end
         if (doWrite && paramOpen) begin
            case (avsAddress)
               `REG_SCALE:       scale <= {18'h00000, avsWriteData[13:8], 2'h0, avsWriteData[5:0]};
               `REG_TOP_BASE:    topBase <= {avsWriteData[31:2], 2'h0};
               `REG_BOTTOM_BASE: bottomBase <= {avsWriteData[31:2], 2'h0};
               `REG_STRIDE:      stride <= {avsWriteData[31:2], 2'h0};
               `REG_WINDOW:      window <= avsWriteData;
               default:          ;
            endcase
         end
      end
   end

   // ==========================================
   // Capture sequencer
   // top-only field gate
   wire       topOnly     = ~field_display_select;
   wire       fieldWanted = ~(topOnly & curBottom);
   wire [1:0] fieldsNeed  = topOnly ? 2'h1 : 2'h2;
   wire [1:0] fieldsNext  = fieldsDone + {1'b0, fieldWanted};
   reg  [2:0] next_state;

   assign grabDone = (state == ST_GRAB) & vidVsync & (fieldsNext >= fieldsNeed);

   always @* begin
      next_state = state;
      case (state)
         ST_LIVE:
            if (capture_mode)
               next_state = ST_FREEZE_WAIT;
         ST_FREEZE_WAIT:
            if (vidVsync)
               next_state = capture_mode ? ST_FROZEN : ST_LIVE;
         ST_FROZEN:
            if (grab_trigger)
               next_state = ST_GRAB_WAIT;
            else if (!capture_mode)
               next_state = ST_RESUME_WAIT;
         // grab starts at next vertical sync
         ST_GRAB_WAIT:
            if (vidVsync)
               next_state = ST_GRAB;
         ST_GRAB:
            if (grabDone)
               next_state = ST_FROZEN;
         // live display back at next vertical sync
         ST_RESUME_WAIT:
            if (vidVsync)
               next_state = capture_mode ? ST_FROZEN : ST_LIVE;
         default:
            next_state = ST_LIVE;
      endcase
   end

   always @(posedge clk) begin
      if (reset) begin
         state      <= ST_LIVE;
         fieldsDone <= 2'h0;
         curBottom  <= 1'b0;
      end else begin
         state <= next_state;
         if (vidVsync)
            curBottom <= vidOddField;
         // count one field or two per grab
         if (state == ST_GRAB_WAIT)
            fieldsDone <= 2'h0;
         else if (state == ST_GRAB && vidVsync)
            fieldsDone <= fieldsNext;
      end
   end

   wire streaming = (state == ST_LIVE) | (state == ST_FREEZE_WAIT) | (state == ST_GRAB);
   wire dmaAllowed = busMasterEnable & video_dma_on & streaming;

   // ==========================================
   // Input, filter and downscale
   wire        advance = ~dmaValid | dmaReady;
   wire        take    = vidValid & advance;
   reg  [39:0] yHist;
   reg  [31:0] uHist;
   reg  [31:0] vHist;
   reg         chromaV;
   reg  [5:0]  hPhase;
   reg  [5:0]  vPhase;
   reg  [DIM_W-1:0] pixCount;
   reg  [DIM_W-1:0] lineCount;
   reg         lineKeep;
   reg         firstLine;
   reg         s2Valid;
   reg         s2Start;
   reg  [7:0]  s2Y, s2U, s2V;

   assign vidReady = advance;

   // bottom field shifted half a group in duplicate mode
   wire [5:0] vPos      = (field_dup_mode & curBottom) ? vPhase + `DUP_PHASE : vPhase;
   wire       lineHit   = dropHit(vPos, vert_drop_count);
   wire       lineOk    = ~lineHit & (lineCount < window_height) & fieldWanted;
   wire       curKeep   = vidLineStart ? lineOk : lineKeep;
   wire       pixHit    = dropHit(vidLineStart ? 6'h00 : hPhase, horiz_drop_count);
   wire [DIM_W-1:0] pixUse = vidLineStart ? {DIM_W{1'b0}} : pixCount;
   wire       pixKeep   = curKeep & ~pixHit & (pixUse < window_width);
   wire [39:0] yNew     = {yHist[31:0], vidY};
   wire [31:0] uNew     = chromaV ? uHist : {uHist[23:0], vidC};
   wire [31:0] vNew     = chromaV ? {vHist[23:0], vidC} : vHist;

   always @(posedge clk) begin
      if (reset) begin
         yHist <= 40'h0000000000; uHist <= 32'h00000000; vHist <= 32'h00000000;
         chromaV <= 1'b0; hPhase <= 6'h00; vPhase <= 6'h00;
         pixCount <= {DIM_W{1'b0}}; lineCount <= {DIM_W{1'b0}};
         lineKeep <= 1'b0; firstLine <= 1'b1;
         s2Valid <= 1'b0; s2Start <= 1'b0;
         s2Y <= 8'h00; s2U <= 8'h00; s2V <= 8'h00;
      end else begin
         if (vidVsync) begin
            vPhase    <= 6'h00;
            lineCount <= {DIM_W{1'b0}};
            firstLine <= 1'b1;
         end
         if (advance)
            s2Valid <= 1'b0;
         if (take) begin
            yHist   <= yNew;
            uHist   <= uNew;
            vHist   <= vNew;
            chromaV <= vidLineStart ? 1'b1 : ~chromaV;
            hPhase  <= (vidLineStart ? 6'h00 : hPhase) + 6'h01;
            // line phase advances apart from pixel phase
            if (vidLineStart && !vidVsync) begin
               vPhase   <= vPhase + 6'h01;
               lineKeep <= lineOk;
               if (lineOk) begin
                  lineCount <= lineCount + {{(DIM_W-1){1'b0}}, 1'b1};
                  firstLine <= 1'b0;
               end
            end
            pixCount <= pixUse + {{(DIM_W-1){1'b0}}, pixKeep};
            s2Valid  <= pixKeep;
            s2Start  <= pixKeep & (pixUse == {DIM_W{1'b0}});
            s2Y <= filt(horiz_filter_select, 1'b1, yNew);
            s2U <= filt(horiz_filter_select, 1'b0, {8'h00, uNew});
            s2V <= filt(horiz_filter_select, 1'b0, {8'h00, vNew});
         end
      end
   end

   // ==========================================
   // Colour conversion and word packing
   wire signed [17:0] cy = {10'h000, s2Y};
   wire signed [17:0] cu = {10'h000, s2U} - 18'sd128;
   wire signed [17:0] cv = {10'h000, s2V} - 18'sd128;
   wire signed [17:0] mR = (18'sd359 * cv) >>> 8;
   wire signed [17:0] mG = (18'sd88 * cu + 18'sd183 * cv) >>> 8;
   wire signed [17:0] mB = (18'sd454 * cu) >>> 8;
   wire [7:0]  r8 = clamp(cy + mR);
   wire [7:0]  g8 = clamp(cy - mG);
   wire [7:0]  b8 = clamp(cy + mB);
   reg  [2:0]  errR, errG, errB;
   reg         halfFull;
   reg  [15:0] halfWord;
   reg  [7:0]  halfU;
   reg  [31:0] lineAddr;
   reg  [31:0] wordAddr;
   reg         lineStarted;

   // carry the truncated remainder into the next pixel
   wire [3:0]  eR = error_diffusion_on ? {1'b0, errR} : 4'h0;
   wire [3:0]  eG = error_diffusion_on ? {1'b0, errG} : 4'h0;
   wire [3:0]  eB = error_diffusion_on ? {1'b0, errB} : 4'h0;
   wire [8:0]  dR = {1'b0, r8} + {5'h00, eR};
   wire [8:0]  dG = {1'b0, g8} + {5'h00, (color_convert_select == 2'h2) ? {1'b0, eG[3:1]} : eG};
   wire [8:0]  dB = {1'b0, b8} + {5'h00, eB};
   wire [7:0]  qR = dR[8] ? 8'hFF : dR[7:0];
   wire [7:0]  qG = dG[8] ? 8'hFF : dG[7:0];
   wire [7:0]  qB = dB[8] ? 8'hFF : dB[7:0];
   wire [15:0] px565 = {qR[7:3], qG[7:2], qB[7:3]};
   wire [15:0] px555 = {1'b0, qR[7:3], qG[7:3], qB[7:3]};
   wire [15:0] px16  = (color_convert_select == 2'h2) ? px565 : px555;
   wire        wide  = (color_convert_select == 2'h1);
   wire        yuv   = (color_convert_select == 2'h0);
   wire        useHalf = s2Start ? 1'b0 : halfFull;
   // per-field base, then stride per kept line
   wire [31:0] fieldBase = curBottom ? bottomBase : topBase;
   wire [31:0] startAddr = (firstLine | ~lineStarted) ? fieldBase : lineAddr + stride;
   wire [31:0] curAddr   = s2Start ? startAddr : wordAddr;

   always @(posedge clk) begin
      if (reset) begin
         dmaValid <= 1'b0; dmaAddress <= `RST_WORD; dmaData <= `RST_WORD;
         errR <= 3'h0; errG <= 3'h0; errB <= 3'h0;
         halfFull <= 1'b0; halfWord <= 16'h0000; halfU <= 8'h00;
         lineAddr <= `RST_WORD; wordAddr <= `RST_WORD; lineStarted <= 1'b0;
      end else begin
         if (dmaReady)
            dmaValid <= 1'b0;
         if (vidVsync)
            lineStarted <= 1'b0;
         if (advance && s2Valid) begin
            errR <= (color_convert_select == 2'h0 || s2Start) ? 3'h0 : qR[2:0];
            errG <= (color_convert_select == 2'h2) ? {1'b0, qG[1:0]} : qG[2:0];
            errB <= s2Start ? 3'h0 : qB[2:0];
            if (s2Start) begin
               lineAddr    <= startAddr;
               lineStarted <= 1'b1;
            end
            if (wide || useHalf) begin
               // emit a word only when streaming is allowed
               dmaValid   <= dmaAllowed;
               dmaAddress <= curAddr;
               wordAddr   <= curAddr + 32'h00000004;
               if (wide)
                  dmaData <= {8'h00, qR, qG, qB};
               else if (yuv)
                  dmaData <= {s2Y, s2V, halfWord[15:8], halfU};
               else
                  dmaData <= {px16, halfWord};
               halfFull <= 1'b0;
            end else begin
               if (s2Start)
                  wordAddr <= startAddr;
               halfWord <= yuv ? {s2Y, 8'h00} : px16;
               halfU    <= s2U;
               halfFull <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> inc/video_scale_convert_capture_defs.vh
// Function
// - Filter select 0: no luma filter, 3-tap chroma; 1: 3-tap luma and chroma.
// - Selects 2 and 4: two different 4-tap filters, each shared by luma and chroma; 3: 5-tap luma, 4-tap chroma.
// - Horizontal and vertical downscaling are configured and run independently.
// - Horizontal drop count 0..63 drops that many pixels per 64; zero passes all.
// - Vertical drop count 0..63 drops that many lines per 64; zero passes all.
// - Field duplicate mode set gives top and bottom fields different drop patterns.
// - Colour select: 00 YUV 4:2:2, 01 RGB 888, 10 RGB 565, 11 RGB 555.
// - Error diffusion bit enables quantisation error diffusion; advised for 15/16-bit RGB.
// - Video DMA issues writes only while bus-master enable and video DMA enable are set.
// - Writes land in a rectangle of field base, stride, height and width.
// - Field display select chooses both fields or the top field only.
// - Separate top and bottom bases allow two distinct rectangles.
// - In capture mode each 0-to-1 grab trigger transfers one frame or field.
// - Entering capture mode waits for vertical sync, then freezes the display.
// - With capture mode set and grab trigger clear, parameters may be rewritten.
// - After grab trigger is set, wait for vertical sync, then write two fields, or the top field only in top-only mode.
// - Device clears the grab trigger once the last captured field is written.
// - After capture mode clears, live display resumes at the next vertical sync.
`ifndef VIDEO_SCALE_CONVERT_CAPTURE_DEFS_VH
`define VIDEO_SCALE_CONVERT_CAPTURE_DEFS_VH

// ==========================================
// Register byte offsets
`define REG_CONTROL     5'h00
`define REG_SCALE       5'h04
`define REG_TOP_BASE    5'h08
`define REG_BOTTOM_BASE 5'h0C
`define REG_STRIDE      5'h10
`define REG_WINDOW      5'h14
`define REG_STATUS      5'h18

// ==========================================
// Control register fields
`define CTL_DMA_ON      0
`define CTL_FIELD_DISP  1
`define CTL_CAPTURE     2
`define CTL_GRAB        3
`define CTL_DUP         4
`define CTL_ERROR_DIFFUSION_ON      5
`define CTL_COLOR_LO    6
`define CTL_COLOR_HI    7
`define CTL_FILTER_LO   8
`define CTL_FILTER_HI   10

// ==========================================
// Reset values
`define RST_CONTROL     32'h00000000
`define RST_WORD        32'h00000000

// ==========================================
// Timing and geometry
`define GROUP_SIZE      7'h40
`define DUP_PHASE       6'h20
`define ACK_WAIT        1

`endif

// >>> verif/pci_mem_model.sv
`default_nettype none
module pci_mem_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Word port from the DMA engine
   input  wire logic wordValid,
   output var  logic wordReady,
   // Stall each offered word for one cycle when set
   input  wire logic slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phase;

   // ==========================================
   // Acceptance pacing
   // memory takes every word, slow or prompt
   always @(posedge clk) begin
      if (reset) begin
         phase <= 1'b0;
      end else if (wordValid) begin
         phase <= !phase;
      end
   end
   assign wordReady = !slow || phase;
endmodule
`default_nettype wire

// >>> verif/tb_video_scale_convert_capture.sv
`include "video_scale_convert_capture_defs.vh"
`default_nettype none
module tb_video_scale_convert_capture;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, avsRead, avsWrite, avsWaitRequest, busMasterEnable;
   logic [4:0]  avsAddress;
   logic [31:0] avsWriteData, avsReadData, dmaAddress, dmaData, rd;
   logic        vidValid, vidReady, vidLineStart, vidVsync, vidOddField;
   logic [7:0]  vidY, vidC;
   logic        dmaValid, dmaReady, slow;
   logic [31:0] aq[$], dq[$];
   int          err_count, n_compared;
   int          hdrop[4] = '{0, 16, 32, 63};

   video_scale_convert_capture #(.DIM_W(12)) i_dut (
      .clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .busMasterEnable(busMasterEnable),
      .vidValid(vidValid), .vidReady(vidReady), .vidY(vidY), .vidC(vidC),
      .vidLineStart(vidLineStart), .vidVsync(vidVsync), .vidOddField(vidOddField),
      .dmaValid(dmaValid), .dmaReady(dmaReady), .dmaAddress(dmaAddress),
      .dmaData(dmaData));
   pci_mem_model i_mem (.clk(clk), .reset(reset), .wordValid(dmaValid),
      .wordReady(dmaReady), .slow(slow));

   initial begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end

   always @(posedge clk) begin
      if (dmaValid && dmaReady) begin
         aq.push_back(dmaAddress);
         dq.push_back(dmaData);
      end
   end

   // ==========================================
   // Shared tasks
   task automatic print_verdict;
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      do @(posedge clk); while (avsWaitRequest !== 1'b0);
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk);
   endtask

   task automatic line(input int n, input logic [7:0] y0, input logic inc);
      for (int i = 0; i < n; i++) begin
         vidValid <= 1'b1;
         vidLineStart <= (i == 0);
         vidY <= inc ? y0 + i[7:0] : y0;
         vidC <= 8'h80;
         do @(posedge clk); while (vidReady !== 1'b1);
      end
      vidValid <= 1'b0;
      vidLineStart <= 1'b0;
      @(posedge clk);
   endtask

   // Field start also forgets the words of the previous field
   task automatic vs(input logic odd);
      aq.delete();
      dq.delete();
      vidVsync <= 1'b1;
      vidOddField <= odd;
      @(posedge clk);
      vidVsync <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic drain(input int n);
      repeat (24) @(posedge clk);
      check(32'(aq.size()), 32'(n));
   endtask

   // ==========================================
   // Main sequence
   initial begin
      reset = 1'b1;
      avsAddress = 5'h00;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWriteData = 32'h00000000;
      busMasterEnable = 1'b1;
      {vidValid, vidLineStart, vidVsync, vidOddField} = 4'h0;
      vidY = 8'h00;
      vidC = 8'h80;
      slow = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         bus(1'b0, 5'(a * 4), 32'h0);
         check(rd, `RST_WORD);
      end
      bus(1'b1, 5'h1C, 32'hFFFFFFFF);
      bus(1'b0, 5'h1C, 32'h0);
      check(rd, 32'h00000000);
      bus(1'b1, `REG_STRIDE, 32'h00000103);
      bus(1'b0, `REG_STRIDE, 32'h0);
      check(rd, 32'h00000100);
      bus(1'b1, `REG_TOP_BASE, 32'h00001000);
      bus(1'b1, `REG_BOTTOM_BASE, 32'h00008000);
      bus(1'b1, `REG_WINDOW, 32'h00400040);
      // Horizontal drop counts, with a stalling memory on the first
      foreach (hdrop[k]) begin
         int n;
         n = hdrop[k];
         slow <= (n == 0);
         bus(1'b1, `REG_SCALE, 32'(n));
         bus(1'b1, `REG_CONTROL, 32'h3);
         bus(1'b1, `REG_SCALE, 32'h5);
         bus(1'b0, `REG_SCALE, 32'h0);
         check(rd, 32'(n));
         vs(1'b0);
         line(64, 8'h00, 1'b1);
         drain((64 - n) / 2);
         if (n == 32) begin
            check({dq[0][31:24], dq[0][15:8]}, 32'h0200);
         end
         if (n != 63) begin
            check(aq[0], 32'h00001000);
         end
         bus(1'b1, `REG_CONTROL, 32'h0);
      end
      slow <= 1'b0;
      // Vertical drop of one line in 64, bottom field
      bus(1'b1, `REG_SCALE, 32'h00000100);
      for (int dup = 0; dup < 2; dup++) begin
         bus(1'b1, `REG_CONTROL, 32'h3 | 32'(dup << 4));
         vs(1'b1);
         repeat (32) line(2, 8'h10, 1'b1);
         drain(32 - dup);
         check(aq[0], 32'h00008000);
         check(aq[1], 32'h00008100);
         bus(1'b1, `REG_CONTROL, 32'h0);
      end
      bus(1'b1, `REG_SCALE, 32'h0);
      bus(1'b1, `REG_CONTROL, 32'h1);
      vs(1'b1);
      line(4, 8'h10, 1'b1);
      drain(0);
      bus(1'b1, `REG_CONTROL, 32'h0);
      // Colour formats
      for (int cs = 0; cs < 4; cs++) begin
         bus(1'b1, `REG_CONTROL, 32'h3 | 32'(cs << 6) | (cs >= 2 ? 32'h20 : 32'h0));
         vs(1'b0);
         line(2, 8'h80, 1'b0);
         drain((cs == 1) ? 2 : 1);
         if (cs == 0) check(dq[0][31:24], 32'h80);
         if (cs == 1) check(dq[0], 32'h00808080);
         if (cs == 3) check({dq[0][31], dq[0][15]}, 32'h0);
         bus(1'b1, `REG_CONTROL, 32'h0);
      end
      // Flat input must pass every filter unchanged
      for (int f = 0; f < 5; f++) begin
         bus(1'b1, `REG_CONTROL, 32'h3 | 32'(f << 8));
         vs(1'b0);
         line(8, 8'h80, 1'b0);
         drain(4);
         check({dq[2][31:24], dq[2][15:8]}, 32'h8080);
         bus(1'b1, `REG_CONTROL, 32'h0);
      end
      // Either enable missing means no words
      for (int e = 0; e < 2; e++) begin
         busMasterEnable <= e[0];
         bus(1'b1, `REG_CONTROL, 32'(e == 0 ? 3 : 2));
         vs(1'b0);
         line(4, 8'h20, 1'b1);
         drain(0);
         bus(1'b1, `REG_CONTROL, 32'h0);
      end
      busMasterEnable <= 1'b1;
      // Capture_mode: freeze, grab two fields, resume
      bus(1'b1, `REG_CONTROL, 32'h3);
      vs(1'b0);
      bus(1'b1, `REG_CONTROL, 32'h7);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rd & 32'h7, 32'h1);
      vs(1'b0);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rd & 32'h7, 32'h2);
      line(4, 8'h30, 1'b1);
      drain(0);
      bus(1'b1, `REG_TOP_BASE, 32'h00004000);
      bus(1'b0, `REG_TOP_BASE, 32'h0);
      check(rd, 32'h00004000);
      bus(1'b1, `REG_CONTROL, 32'hF);
      vs(1'b0);
      line(4, 8'h30, 1'b1);
      drain(2);
      check(aq[0], 32'h00004000);
      vs(1'b1);
      line(4, 8'h30, 1'b1);
      drain(2);
      check(aq[0], 32'h00008000);
      vs(1'b0);
      bus(1'b0, `REG_CONTROL, 32'h0);
      check(rd & 32'h8, 32'h0);
      bus(1'b1, `REG_TOP_BASE, 32'h00001000);
      bus(1'b1, `REG_CONTROL, 32'h3);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rd & 32'h7, 32'h5);
      vs(1'b0);
      bus(1'b0, `REG_STATUS, 32'h0);
      check(rd & 32'h7, 32'h0);
      line(4, 8'h40, 1'b1);
      drain(2);
      print_verdict();
   end

   // Whole run is under two thousand cycles
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire

// >>> verif/video_scale_convert_capture_assertions.sv
`default_nettype none
module video_scale_convert_capture_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Register bus
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsReadData,
   input wire logic        avsWaitRequest,
   // Video and DMA
   input wire logic        busMasterEnable,
   input wire logic        vidValid,
   input wire logic        vidReady,
   input wire logic        dmaValid,
   input wire logic        dmaReady,
   input wire logic [31:0] dmaAddress,
   input wire logic [31:0] dmaData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ==========================================
   // Bus handshake steps
   sequence s_req;
      (avsRead || avsWrite) && avsWaitRequest;
   endsequence
   sequence s_ans;
      (avsRead || avsWrite) && !avsWaitRequest;
   endsequence

   a_bus_two_cycle: assert property (s_req |=> s_ans)
      else $error("register request not answered in its second cycle");
   a_read_hold: assert property ($changed(avsReadData) |-> $past(avsRead))
      else $error("read data changed without a read");

   // ==========================================
   // Pixel and word flow
   a_word_release: assert property ($fell(dmaValid) |-> $past(dmaReady))
      else $error("pending word withdrawn before acceptance");
   a_word_hold: assert property (dmaValid && !dmaReady |=>
      dmaValid && $stable(dmaAddress) && $stable(dmaData))
      else $error("pending word changed before acceptance");
   a_master_gate: assert property ($rose(dmaValid) |-> busMasterEnable)
      else $error("word issued without bus-master enable");
   a_word_aligned: assert property (dmaValid |-> dmaAddress[1:0] == 2'h0)
      else $error("word address not aligned");
   a_word_cause: assert property ($rose(dmaValid) |-> $past(vidValid && vidReady)
      || $past(vidValid && vidReady, 2) || $past(vidValid && vidReady, 3))
      else $error("word appeared without a recent pixel");
   a_reset_clear: assert property (disable iff (1'b0) reset |=> !dmaValid)
      else $error("word pending after reset");
endmodule

bind video_scale_convert_capture video_scale_convert_capture_assertions i_check (
   .clk(clk), .reset(reset), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
   .busMasterEnable(busMasterEnable), .vidValid(vidValid), .vidReady(vidReady),
   .dmaValid(dmaValid), .dmaReady(dmaReady), .dmaAddress(dmaAddress),
   .dmaData(dmaData));
`default_nettype wire
